/* File: rtl/pfm_framer_ctrl.sv */
/*
 Mode control of a PCM 30 framer: register file, resync control, slot 0 assembly,
 loop back and idle substitution, parity check and alarm interrupt output.
 Assumes slot strobes, frame flags and slot data come from framer logic on the same clock.
*/
`timescale 1ns/1ns
module pfm_framer_ctrl #(
   parameter int MF_WINDOW = pfm_pkg::MF_WINDOW_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tx_slot_strobe,
   input wire logic [4:0] tx_slot_num,
   input wire logic tx_frame_odd,
   input wire logic tx_crc_bit,
   input wire logic [7:0] system_tx_input,
   output logic [7:0] line_tx_data,
   output logic [7:0] test_tx_data,
   output logic line_tx_valid,
   output logic dual_rail_enable,
   output logic fibre_line_select,
   output logic code_violation_check,
   input wire logic rx_slot_strobe,
   input wire logic [4:0] rx_slot_num,
   input wire logic rx_frame_odd,
   input wire logic [7:0] rx_slot_data,
   input wire logic rx_parity_bit,
   input wire logic df_aligned,
   input wire logic mf_pattern_found,
   input wire logic slip_detected,
   input wire logic tx_mf_begin,
   input wire logic rx_mf_begin,
   output logic df_search_restart,
   output logic mf_search_restart,
   output logic crc_multiframe_mode,
   output logic single_frame_buffer,
   output logic slip_flag,
   output logic loopback_active,
   output logic parity_flag_pin
);
   import pfm_pkg::*;

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------
   logic [7:0] ccr, mode, parity_check_channel, loopback_channel_select;
   logic [7:0] service_word_transmit, spare_bits_transmit, alarm_mask, idle_code;
   logic [7:0] extended_mode_register, national_bit_tx_stack;
   logic [7:0] service_word_receive, national_bit_rx_stack;
   logic [7:0] ctrl_bank [4];
   logic [7:0] idle_bank [4];
   logic [7:0] rd_byte;
   logic multiframe_resync_cmd_prev, frs_prev, df_prev, tx_mfb_prev, rx_mfb_prev;
   logic tx_mfb_pend, rx_mfb_pend, parity_alarm;
   logic [16:0] window_cnt;
   logic [1:0] pattern_cnt;
   pfm_sync_t sync_state, next_sync_state;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire [3:0] idx = wb_adr_i[5:2];
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_req = bus_req && wb_we_i && wb_sel_i[0];
   wire rd_req = bus_req && !wb_we_i;
   wire bank_sw = parity_check_channel[CPY_SW];
   wire in_bank = (idx >= IDX_BANK0) && (idx <= IDX_BANK3);
   wire [1:0] bank_idx = 2'(idx - IDX_BANK0);
   wire wr_ccr = wr_req && idx == IDX_CCR;
   wire wr_mode = wr_req && idx == IDX_MODE && !bank_sw;
   wire wr_extended_mode_register = wr_req && idx == IDX_MODE && bank_sw;
   wire wr_cpy = wr_req && idx == IDX_CPY;
   wire wr_loop = wr_req && idx == IDX_LOOP;
   wire wr_xsw = wr_req && idx == IDX_XSW;
   wire wr_xsp = wr_req && idx == IDX_XSP;
   wire wr_ctrl_bank = wr_req && in_bank && !bank_sw;
   wire wr_idle_bank = wr_req && in_bank && bank_sw;
   wire wr_xsn = wr_req && idx == IDX_XSN;
   wire wr_mask = wr_req && idx == IDX_MASK;
   wire wr_idle = wr_req && idx == IDX_IDLE;
   wire stack_access = bus_req && idx == IDX_XSN;
   wire [7:0] wdat = wb_dat_i[7:0];

   // Acknowledge is a write-one pulse; the stored bit never holds it
   wire alarm_ack = wr_loop && wdat[LOOP_AIA];

   // -----------------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------------
   wire crc_en = mode[MODE_CRC];
   wire doubleframe_national_option = extended_mode_register[EXTENDED_MODE_REGISTER_DOUBLEFRAME_NATIONAL_OPTION];
   wire crc_mf = crc_en && !doubleframe_national_option;
   wire stack_en = mode[MODE_NATIONAL_BIT_STACK_ENABLE] && crc_en;
   wire tt0 = spare_bits_transmit[XSP_TT0];
   wire slot_zero_extended_transparent = extended_mode_register[EXTENDED_MODE_REGISTER_SLOT_ZERO_EXTENDED_TRANSPARENT];
   wire slot_zero_signaling_transparent = spare_bits_transmit[XSP_SLOT_ZERO_SIGNALING_TRANSPARENT];
   wire alarm_interrupt_output_en = ccr[CCR_ALARM_INTERRUPT_OUTPUT];
   pfm_transp_t transp;
   assign transp = tt0 ? PFM_TR_FULL : (slot_zero_extended_transparent ? PFM_TR_EXT : (slot_zero_signaling_transparent ? PFM_TR_SIG : PFM_TR_NONE));
   wire any_transp = transp != PFM_TR_NONE;

   // -----------------------------------------------------------------
   // Command edges
   // -----------------------------------------------------------------
   // Held command bits would otherwise restart the search every cycle
   wire multiframe_resync_cmd_rise = mode[MODE_MULTIFRAME_RESYNC_CMD] && !multiframe_resync_cmd_prev && crc_mf;
   wire frs_rise = ccr[CCR_FRS] && !frs_prev;
   wire df_rise = df_aligned && !df_prev;
   wire window_over = window_cnt == 17'(MF_WINDOW - 1);

   // -----------------------------------------------------------------
   // Multiframe search control
   // -----------------------------------------------------------------
   always_comb begin
      next_sync_state = sync_state;
      df_search_restart = 1'b0;
      mf_search_restart = 1'b0;
      if (frs_rise) begin
         df_search_restart = 1'b1;
         mf_search_restart = crc_mf;
         next_sync_state = PFM_DF_SEARCH;
      end else if (!crc_mf) begin
         next_sync_state = PFM_DF_SEARCH;
      end else if (multiframe_resync_cmd_rise) begin
         mf_search_restart = 1'b1;
         next_sync_state = PFM_MF_SEARCH;
      end else begin
         unique case (sync_state)
            PFM_DF_SEARCH: begin
               if (df_rise) begin
                  next_sync_state = PFM_MF_SEARCH;
               end
            end
            PFM_MF_SEARCH: begin
               if (!df_aligned) begin
                  next_sync_state = PFM_DF_SEARCH;
               end else if (mf_pattern_found && pattern_cnt == 2'd1) begin
                  next_sync_state = PFM_MF_LOCKED;
               end else if (window_over && mode[MODE_AFR]) begin
                  df_search_restart = 1'b1;
                  mf_search_restart = 1'b1;
                  next_sync_state = PFM_DF_SEARCH;
               end
            end
            PFM_MF_LOCKED: begin
               if (!df_aligned) begin
                  next_sync_state = PFM_DF_SEARCH;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_state <= PFM_DF_SEARCH;
         window_cnt <= '0;
         pattern_cnt <= '0;
      end else begin
         sync_state <= next_sync_state;
         if (next_sync_state != PFM_MF_SEARCH || sync_state != PFM_MF_SEARCH || multiframe_resync_cmd_rise) begin
            window_cnt <= '0;
            pattern_cnt <= '0;
         end else begin
            if (!window_over) begin
               window_cnt <= window_cnt + 17'd1;
            end
            if (mf_pattern_found) begin
               pattern_cnt <= 2'd1;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ccr <= RST_ZERO;
         mode <= RST_ZERO;
         parity_check_channel <= RST_CPY;
         loopback_channel_select <= RST_ZERO;
         service_word_transmit <= RST_XSW;
         spare_bits_transmit <= RST_ZERO;
         extended_mode_register <= RST_ZERO;
         alarm_mask <= RST_ZERO;
         idle_code <= RST_ZERO;
         national_bit_tx_stack <= RST_ZERO;
         ctrl_bank <= '{RST_ZERO, RST_ZERO, RST_RC0, RST_ZERO};
         idle_bank <= '{default: RST_ZERO};
      end else begin
         if (wr_ccr) ccr <= wdat;
         if (wr_mode) mode <= wdat;
         if (wr_extended_mode_register) extended_mode_register <= wdat;
         if (wr_cpy) parity_check_channel <= wdat;
         if (wr_loop) loopback_channel_select <= {1'b0, wdat[6:0]};
         if (wr_xsw) service_word_transmit <= wdat;
         if (wr_xsp) spare_bits_transmit <= wdat;
         if (wr_ctrl_bank) ctrl_bank[bank_idx] <= wdat;
         if (wr_idle_bank) idle_bank[bank_idx] <= wdat;
         if (wr_xsn) national_bit_tx_stack <= wdat;
         if (wr_mask) alarm_mask <= wdat;
         if (wr_idle) idle_code <= wdat;
      end
   end

   // -----------------------------------------------------------------
   // Read mux
   // -----------------------------------------------------------------
   wire control_readback_test = ccr[CCR_CRD];
   always_comb begin
      rd_byte = 8'h00;
      if (control_readback_test) begin
         unique case (idx)
            IDX_CCR: rd_byte = ccr;
            IDX_MODE: rd_byte = bank_sw ? extended_mode_register : mode;
            IDX_CPY: rd_byte = parity_check_channel;
            IDX_LOOP: rd_byte = loopback_channel_select;
            IDX_XSW: rd_byte = service_word_transmit;
            IDX_XSP: rd_byte = spare_bits_transmit;
            IDX_MASK: rd_byte = alarm_mask;
            IDX_IDLE: rd_byte = idle_code;
            default: rd_byte = in_bank ? (bank_sw ? idle_bank[bank_idx] : ctrl_bank[bank_idx]) : 8'h00;
         endcase
      end else begin
         unique case (idx)
            IDX_XSW: rd_byte = service_word_receive;
            IDX_XSP: rd_byte = {3'b000, tx_mfb_pend, rx_mfb_pend, parity_alarm, 2'(sync_state)};
            IDX_XSN: rd_byte = national_bit_rx_stack;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         if (rd_req) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   // -----------------------------------------------------------------
   // Transmit slot assembly
   // -----------------------------------------------------------------
   wire [4:0] cla = loopback_channel_select[4:0];
   wire loop_on = cla != 5'd0 && !loopback_channel_select[LOOP_LOOPBACK_DISABLE];
   wire idle_sel = idle_bank[tx_slot_num[4:3]][tx_slot_num[2:0]];
   wire loop_hit = loop_on && tx_slot_num == cla;
   wire [4:0] nat_reg = stack_en ? national_bit_tx_stack[4:0] : service_word_transmit[4:0];
   wire [4:0] nat_bits = any_transp ? system_tx_input[4:0] : nat_reg;
   wire si_reg = crc_mf ? tx_crc_bit : service_word_transmit[XSW_INTL_SPARE_BIT_TX];
   wire si_bit = any_transp ? system_tx_input[7] : si_reg;
   wire ra_bit = service_word_transmit[XSW_XRA];
   wire [7:0] fas_byte = {si_bit, FAS_PATTERN};
   wire [7:0] svc_byte = {si_bit, 1'b1, ra_bit, nat_bits};
   wire [7:0] ts0_byte = (transp == PFM_TR_FULL) ? system_tx_input
                                                 : (tx_frame_odd ? svc_byte : fas_byte);
   wire [7:0] normal_byte = (tx_slot_num == 5'd0) ? ts0_byte : system_tx_input;
   wire [7:0] line_byte = (loop_hit || idle_sel) ? idle_code : normal_byte;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         line_tx_data <= AIS_BYTE;
         test_tx_data <= 8'h00;
         line_tx_valid <= 1'b0;
      end else begin
         line_tx_valid <= tx_slot_strobe;
         if (tx_slot_strobe) begin
            line_tx_data <= mode[MODE_REMOTE_AIS_SEND] ? AIS_BYTE : line_byte;
            test_tx_data <= line_byte;
         end
      end
   end

   // -----------------------------------------------------------------
   // Receive side: service word, stack, parity
   // -----------------------------------------------------------------
   wire [4:0] cpa = parity_check_channel[4:0];
   wire parity_hit = rx_slot_strobe && rx_slot_num == cpa && !parity_check_channel[CPY_PARITY_CHECK_DISABLE];
   wire parity_bad = parity_hit && ((^rx_slot_data) != rx_parity_bit);
   wire svc_rx = rx_slot_strobe && rx_slot_num == 5'd0 && rx_frame_odd;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         service_word_receive <= 8'h00;
         national_bit_rx_stack <= 8'h00;
         parity_alarm <= 1'b0;
         slip_flag <= 1'b0;
      end else begin
         if (svc_rx && !stack_en) service_word_receive <= rx_slot_data;
         if (svc_rx && stack_en) national_bit_rx_stack <= {3'b000, rx_slot_data[4:0]};
         // Set wins over clear so an error in the clearing cycle survives
         if (parity_bad) begin
            parity_alarm <= 1'b1;
         end else if (wr_ccr && wdat[CCR_CCPY]) begin
            parity_alarm <= 1'b0;
         end
         // Slip still reported in single-frame mode; data path untouched
         if (slip_detected) begin
            slip_flag <= 1'b1;
         end else if (wr_ccr && wdat[CCR_CCPY]) begin
            slip_flag <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Multiframe-begin interrupt sources
   // -----------------------------------------------------------------
   wire tx_mfb_rise = tx_mf_begin && !tx_mfb_prev;
   wire rx_mfb_rise = rx_mf_begin && !rx_mfb_prev;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         multiframe_resync_cmd_prev <= 1'b0;
         frs_prev <= 1'b0;
         df_prev <= 1'b0;
         tx_mfb_prev <= 1'b0;
         rx_mfb_prev <= 1'b0;
         tx_mfb_pend <= 1'b0;
         rx_mfb_pend <= 1'b0;
      end else begin
         multiframe_resync_cmd_prev <= mode[MODE_MULTIFRAME_RESYNC_CMD];
         frs_prev <= ccr[CCR_FRS];
         df_prev <= df_aligned;
         tx_mfb_prev <= tx_mf_begin;
         rx_mfb_prev <= rx_mf_begin;
         if (tx_mfb_rise && spare_bits_transmit[XSP_TX_MULTIFRAME_BEGIN_MASK]) begin
            tx_mfb_pend <= 1'b1;
         end else if (alarm_ack || (stack_access && wb_we_i)) begin
            tx_mfb_pend <= 1'b0;
         end
         if (rx_mfb_rise && spare_bits_transmit[XSP_RX_MULTIFRAME_BEGIN_MASK]) begin
            rx_mfb_pend <= 1'b1;
         end else if (alarm_ack || (stack_access && !wb_we_i)) begin
            rx_mfb_pend <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Pin outputs
   // -----------------------------------------------------------------
   // Parity alarm only counts as an interrupt source while its mask bit is set
   wire alarm_irq = tx_mfb_pend || rx_mfb_pend || (parity_alarm && alarm_mask[MASK_PARITY]);
   assign parity_flag_pin = alarm_interrupt_output_en ? alarm_irq : parity_alarm;
   assign fibre_line_select = mode[MODE_OPT];
   assign dual_rail_enable = !mode[MODE_OPT];
   assign code_violation_check = !mode[MODE_OPT];
   assign crc_multiframe_mode = crc_mf;
   // Clocks must be phase locked in this mode; the block cannot check that
   assign single_frame_buffer = loopback_channel_select[LOOP_SFM];
   assign loopback_active = loop_on;
endmodule : pfm_framer_ctrl

/* File: rtl/pfm_pkg.sv */
/*
 Constants, register map and field layout of the PCM 30 framer mode control block.
 Assumes one 10 MHz clock and a classic Wishbone slave with 32-bit data, one word per register.
*/
package pfm_pkg;
   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [3:0] IDX_CCR = 4'h0;
   localparam logic [3:0] IDX_MODE = 4'h1;
   localparam logic [3:0] IDX_CPY = 4'h2;
   localparam logic [3:0] IDX_LOOP = 4'h3;
   localparam logic [3:0] IDX_XSW = 4'h4;
   localparam logic [3:0] IDX_XSP = 4'h5;
   localparam logic [3:0] IDX_BANK0 = 4'h6;
   localparam logic [3:0] IDX_BANK3 = 4'h9;
   localparam logic [3:0] IDX_XSN = 4'hB;
   localparam logic [3:0] IDX_MASK = 4'hC;
   localparam logic [3:0] IDX_IDLE = 4'hD;
   // -----------------------------------------------------------------
   // Values after reset
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_CPY = 8'h40;
   localparam logic [7:0] RST_XSW = 8'h40;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_RC0 = 8'h30;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CCR_ALARM_INTERRUPT_OUTPUT = 7;
   localparam int CCR_CRD = 5;
   localparam int CCR_CCPY = 2;
   localparam int CCR_FRS = 1;
   localparam int MODE_MULTIFRAME_RESYNC_CMD = 7;
   localparam int MODE_AFR = 6;
   localparam int MODE_NATIONAL_BIT_STACK_ENABLE = 5;
   localparam int MODE_CRC = 3;
   localparam int MODE_OPT = 2;
   localparam int MODE_REMOTE_AIS_SEND = 0;
   localparam int CPY_SW = 7;
   localparam int CPY_PARITY_CHECK_DISABLE = 5;
   localparam int LOOP_AIA = 7;
   localparam int LOOP_SFM = 6;
   localparam int LOOP_LOOPBACK_DISABLE = 5;
   localparam int XSW_INTL_SPARE_BIT_TX = 7;
   localparam int XSW_XRA = 5;
   localparam int XSP_TX_MULTIFRAME_BEGIN_MASK = 3;
   localparam int XSP_RX_MULTIFRAME_BEGIN_MASK = 2;
   localparam int XSP_TT0 = 1;
   localparam int XSP_SLOT_ZERO_SIGNALING_TRANSPARENT = 0;
   localparam int EXTENDED_MODE_REGISTER_DOUBLEFRAME_NATIONAL_OPTION = 7;
   localparam int EXTENDED_MODE_REGISTER_SLOT_ZERO_EXTENDED_TRANSPARENT = 6;
   localparam int MASK_PARITY = 0;
   localparam logic [6:0] FAS_PATTERN = 7'h1B;
   localparam logic [7:0] AIS_BYTE = 8'hFF;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLOCK_HZ = 10_000_000;
   localparam int MF_WINDOW_MS = 8;
   localparam int MF_WINDOW_CYCLES = MF_WINDOW_MS * (CLOCK_HZ / 1000);
   typedef enum logic [1:0] {PFM_DF_SEARCH, PFM_MF_SEARCH, PFM_MF_LOCKED} pfm_sync_t;
   typedef enum logic [1:0] {PFM_TR_NONE, PFM_TR_SIG, PFM_TR_EXT, PFM_TR_FULL} pfm_transp_t;
endpackage : pfm_pkg

/* File: testbench/pfm_framer_ctrl_properties.sv */
/*
 Port checker of the framer mode control block.
 Assumes binding into pfm_framer_ctrl, one clock, reset active high.
*/
`timescale 1ns/1ns
module pfm_framer_ctrl_properties (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic tx_slot_strobe,
   input wire logic line_tx_valid,
   input wire logic [7:0] line_tx_data,
   input wire logic [7:0] test_tx_data,
   input wire logic dual_rail_enable,
   input wire logic fibre_line_select,
   input wire logic code_violation_check,
   input wire logic mf_search_restart,
   input wire logic crc_multiframe_mode
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_byte_after_slot: assert property (tx_slot_strobe |=> line_tx_valid) else $error("line byte missing");
   a_rail_or_fibre: assert property (dual_rail_enable == !fibre_line_select) else $error("rail clash");
   a_violation_on_rail: assert property (code_violation_check == dual_rail_enable) else $error("cv check");
   a_ais_or_normal: assert property (line_tx_valid |-> line_tx_data == test_tx_data || line_tx_data == 8'hFF)
      else $error("line byte neither normal nor AIS");
   a_restart_single: assert property (mf_search_restart |=> !mf_search_restart) else $error("restart held");
   a_restart_in_crc: assert property (mf_search_restart |-> crc_multiframe_mode) else $error("restart no crc");
endmodule : pfm_framer_ctrl_properties
bind pfm_framer_ctrl pfm_framer_ctrl_properties u_props (.*);

/* File: testbench/pfm_framer_ctrl_tb.sv */
/*
 Self-checking bench of the framer mode control block.
 Assumes the bound checker and the remote line model; 10 MHz clock.
*/
`timescale 1ns/1ns
module pfm_framer_ctrl_tb;
   import pfm_pkg::*;
   logic clock = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, tx_frame_odd = 1'h0;
   logic tx_slot_strobe = 1'h0, tx_crc_bit = 1'h0, tx_mf_begin = 1'h0;
   logic [5:0] wb_adr_i = 6'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [4:0] tx_slot_num = 5'h00, rx_slot_num;
   logic [7:0] system_tx_input = 8'h00, line_tx_data, test_tx_data, rx_slot_data, got;
   logic wb_ack_o, line_tx_valid, dual_rail_enable, fibre_line_select, code_violation_check, rx_slot_strobe;
   logic rx_frame_odd, rx_parity_bit, df_aligned, mf_pattern_found, slip_detected, rx_mf_begin, slip_flag;
   logic df_search_restart, mf_search_restart, crc_multiframe_mode, single_frame_buffer, loopback_active;
   logic parity_flag_pin;
   int mismatches = 0, checked = 0, cycles = 0, mf_n = 0, df_n = 0;
   // ---------------------------------------------------------------
   // Clock, design, far side and timeout
   // ---------------------------------------------------------------
   always #50 clock = ~clock;
   pfm_framer_ctrl #(.MF_WINDOW(50)) dut (.*);
   pfm_remote_line u_line (.*);
   always @(posedge clock) begin
      cycles++;
      mf_n += int'(mf_search_restart === 1'h1);
      df_n += int'(df_search_restart === 1'h1);
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic wb(input logic [3:0] idx, input logic [7:0] d, input logic w);
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, idx, 2'h0, 24'h0, d};
      do @(posedge clock); while (wb_ack_o !== 1'h1);
      got = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask : wb
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic slot(input logic [4:0] n, input logic o, input logic [7:0] d);
      @(posedge clock);
      {tx_slot_strobe, tx_slot_num, tx_frame_odd, system_tx_input} <= {1'h1, n, o, d};
      @(posedge clock);
      tx_slot_strobe <= 1'h0;
      @(negedge clock);
      got = line_tx_data;
   endtask : slot
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      wb(IDX_CCR, 8'h20, 1'h1);
      wb(IDX_CPY, 8'h00, 1'h0);
      check("cpy reset", RST_CPY, got);
      wb(IDX_XSW, 8'h00, 1'h0);
      check("xsw reset", RST_XSW, got);
      wb(4'hE, 8'h00, 1'h0);
      check("unmapped", 8'h00, got);
      wb(IDX_CCR, 8'h00, 1'h1);
      $display("regs done");
   endtask : t_regs
   task automatic t_line();
      wb(IDX_MODE, 8'h04, 1'h1);
      check("fibre", 8'h01, {7'h0, fibre_line_select});
      check("rail off", 8'h00, {7'h0, dual_rail_enable});
      check("cv off", 8'h00, {7'h0, code_violation_check});
      wb(IDX_MODE, 8'h01, 1'h1);
      slot(5'h03, 1'h0, 8'h11);
      check("ais line", AIS_BYTE, got);
      check("ais test", 8'h11, test_tx_data);
      wb(IDX_MODE, 8'h00, 1'h1);
      $display("line done");
   endtask : t_line
   task automatic t_resync();
      wb(IDX_MODE, 8'h08, 1'h1);
      check("crc mode", 8'h01, {7'h0, crc_multiframe_mode});
      {mf_n, df_n} = 64'h0;
      wb(IDX_MODE, 8'h88, 1'h1);
      wb(IDX_MODE, 8'h88, 1'h1);
      repeat (4) @(posedge clock);
      check("mf restarts", 8'h01, 8'(mf_n));
      check("df restarts", 8'h00, 8'(df_n));
      wb(IDX_MODE, 8'h48, 1'h1);
      df_n = 0;
      wb(IDX_MODE, 8'hC8, 1'h1);
      // Long enough to outlast one alignment drop of the line model
      repeat (300) @(posedge clock);
      check("auto resync", 8'h01, 8'(df_n != 0));
      wb(IDX_CPY, 8'hC0, 1'h1);
      wb(IDX_MODE, 8'h80, 1'h1);
      check("doubleframe_national_option mode", 8'h00, {7'h0, crc_multiframe_mode});
      wb(IDX_MODE, 8'h00, 1'h1);
      wb(IDX_CPY, 8'h40, 1'h1);
      wb(IDX_MODE, 8'h00, 1'h1);
      $display("resync done");
   endtask : t_resync
   task automatic t_loop();
      wb(IDX_IDLE, 8'h3C, 1'h1);
      wb(IDX_LOOP, 8'h05, 1'h1);
      check("loop flag", 8'h01, {7'h0, loopback_active});
      slot(5'h05, 1'h0, 8'h11);
      check("looped", 8'h3C, got);
      slot(5'h06, 1'h0, 8'h11);
      check("other slot", 8'h11, got);
      wb(IDX_LOOP, 8'h25, 1'h1);
      slot(5'h05, 1'h0, 8'h11);
      check("loop off", 8'h11, got);
      wb(IDX_LOOP, 8'h40, 1'h1);
      check("single frame", 8'h01, {7'h0, single_frame_buffer});
      slot(5'h05, 1'h0, 8'h11);
      check("loop zero", 8'h11, got);
      wb(IDX_LOOP, 8'h00, 1'h1);
      $display("loop done");
   endtask : t_loop
   task automatic t_slot0();
      wb(IDX_XSW, 8'h20, 1'h1);
      slot(5'h00, 1'h1, 8'h00);
      check("remote alarm", 8'h01, {7'h0, got[5]});
      wb(IDX_XSP, 8'h03, 1'h1);
      slot(5'h00, 1'h1, 8'h5A);
      check("transparent", 8'h5A, got);
      wb(IDX_XSP, 8'h00, 1'h1);
      wb(IDX_XSW, RST_XSW, 1'h1);
      $display("slot0 done");
   endtask : t_slot0
   task automatic t_alarm();
      wb(IDX_XSP, 8'h08, 1'h1);
      wb(IDX_CCR, 8'h80, 1'h1);
      tx_mf_begin <= 1'h1;
      repeat (3) @(negedge clock);
      check("alarm raised", 8'h01, {7'h0, parity_flag_pin});
      wb(IDX_LOOP, 8'h80, 1'h1);
      repeat (3) @(negedge clock);
      check("alarm cleared", 8'h00, {7'h0, parity_flag_pin});
      $display("alarm done");
   endtask : t_alarm
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'h0;
      t_regs();
      t_line();
      t_resync();
      t_loop();
      t_slot0();
      t_alarm();
      conclude();
   end
endmodule : pfm_framer_ctrl_tb

/* File: testbench/pfm_remote_line.sv */
/*
 Remote PCM 30 line equipment feeding the receive side of the block.
 Assumes the receive line clock is the block clock, so both stay phase locked.
*/
`timescale 1ns/1ns
module pfm_remote_line (
   input wire logic clock,
   input wire logic rst,
   output logic rx_slot_strobe,
   output logic [4:0] rx_slot_num,
   output logic rx_frame_odd,
   output logic [7:0] rx_slot_data,
   output logic rx_parity_bit,
   output logic df_aligned,
   output logic mf_pattern_found,
   output logic slip_detected,
   output logic rx_mf_begin
);
   logic [7:0] count;
   // ---------------------------------------------------------------
   // Slot timing off the shared clock
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) count <= 8'h00;
      else count <= count + 8'h01;
   end
   assign rx_slot_strobe = (count[2:0] == 3'h7);
   assign rx_slot_num = count[7:3];
   assign rx_frame_odd = count[7];
   // Data changes every cycle so stale bytes never look valid
   assign rx_slot_data = count;
   assign rx_parity_bit = ^count;
   assign df_aligned = (count != 8'h00);
   // Never finds a multiframe pattern, so the auto resync window runs out
   assign mf_pattern_found = 1'h0;
   assign slip_detected = 1'h0;
   assign rx_mf_begin = 1'h0;
endmodule : pfm_remote_line
